// ==== rtl/auto_reload_timer16.sv ====
// Purpose: 16-bit auto-reload down timer with compare, capture, outputs
// Assumes: AXI4-Lite master, byte-wide register contents in wdata[7:0]
// Notes: Every top output comes from the state register
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`default_nettype none
`include "tmr16_map.svh"

module auto_reload_timer16 (
  input wire logic ref_clk,
  input wire logic rst,
  input wire tmr16_pkg::axi_req_t axiIn,
  output tmr16_pkg::axi_rsp_t axiOut,
  input wire logic eventInA,
  input wire logic eventInB,
  output logic pulseOut,
  output logic overflowOut,
  output logic irq
);

  typedef struct packed {
    logic [1:0] divSel;
    logic reloadEn;
    logic run;
    logic ovfToggleSel;
    logic pulseOutEn;
    logic pulsePol;
    logic pulseToggleSel;
    logic [1:0] startSel;
    logic polA;
    logic polB;
    tmr16_pkg::flags_t flags;
    tmr16_pkg::flags_t irqEn;
    logic [7:0] stage;
    logic [15:0] cmp;
    logic [15:0] reload_capture_reg;
    logic [15:0] mask;
    logic [15:0] cap;
    logic [15:0] count;
    logic started;
    logic runPrev;
    logic pulse;
    logic ovfOut;
    logic irq;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [7:0] wData;
    logic wByte;
    tmr16_pkg::axi_rsp_t rsp;
  } tmr_st_t;

  tmr_st_t st_r;
  tmr_st_t st_nxt;
  logic tick;
  logic evA;
  logic evB;
  logic doWrite;
  logic wrHit;
  logic startEv;
  logic runRise;
  logic counting;
  logic zeroHit;
  logic cmpHit;
  logic ovfHit;
  logic [15:0] effMask;

  // Straight from the state flops
  assign axiOut = st_r.rsp;
  assign pulseOut = st_r.pulse;
  assign overflowOut = st_r.ovfOut;
  assign irq = st_r.irq;

  tick_prescaler u_prescaler (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(st_r.run),
    .divSel(tmr16_pkg::div_sel_t'(st_r.divSel)),
    .tick(tick)
  );

  // Edge finders report edges only while the timer runs
  event_edge_sync u_sync_a (
    .ref_clk(ref_clk),
    .rst(rst),
    .pinIn(eventInA),
    .activeHigh(st_r.polA),
    .enable(st_r.run),
    .edgeSeen(evA)
  );

  event_edge_sync u_sync_b (
    .ref_clk(ref_clk),
    .rst(rst),
    .pinIn(eventInB),
    .activeHigh(st_r.polB),
    .enable(st_r.run),
    .edgeSeen(evB)
  );

  // Read mux; high halves of 16-bit registers read alone
  function automatic logic [32:0] readReg(input tmr_st_t s,
                                          input logic [7:0] a);
    logic [7:0] v;
    logic hit;
    v = 8'h00;
    hit = 1'b1;
    if (a == `TMR16_OFF_CTRL1) begin
      v = {s.divSel, s.reloadEn, s.run, s.irqEn.ovf, s.flags.ovf,
           s.ovfToggleSel, 1'b0};
    end else if (a == `TMR16_OFF_CTRL2) begin
      v = {1'b0, s.polB, s.polA, s.startSel, s.pulseToggleSel,
           s.pulsePol, s.pulseOutEn};
    end else if (a == `TMR16_OFF_IRQEN) begin
      v = {3'h0, s.irqEn};
    end else if (a == `TMR16_OFF_FLAGS) begin
      v = {3'h0, s.flags};
    end else if (a == `TMR16_OFF_CMP_HI) begin
      v = s.cmp[15:8];
    end else if (a == `TMR16_OFF_CMP_LO) begin
      v = s.cmp[7:0];
    end else if (a == `TMR16_OFF_RELOAD_CAPTURE_REG_HI) begin
      v = s.reload_capture_reg[15:8];
    end else if (a == `TMR16_OFF_RELOAD_CAPTURE_REG_LO) begin
      v = s.reload_capture_reg[7:0];
    end else if (a == `TMR16_OFF_MASK_HI) begin
      v = s.mask[15:8];
    end else if (a == `TMR16_OFF_MASK_LO) begin
      v = s.mask[7:0];
    end else if (a == `TMR16_OFF_CAP_HI) begin
      v = s.cap[15:8];
    end else if (a == `TMR16_OFF_CAP_LO) begin
      v = s.cap[7:0];
    end else if (a == `TMR16_OFF_CNT_HI) begin
      v = s.count[15:8];
    end else if (a == `TMR16_OFF_CNT_LO) begin
      v = s.count[7:0];
    end else begin
      hit = 1'b0;
    end
    return {hit, 24'h000000, v};
  endfunction : readReg

  // Bus slave, register writes, counter and outputs in one pass
  always_comb begin
    logic [32:0] rd;
    logic [7:0] d;
    rd = 33'h000000000;
    d = st_r.wData;
    st_nxt = st_r;
    wrHit = 1'b0;
    // Address and data taken in either order, then answered together
    if (axiIn.awvalid && st_r.rsp.awready) begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awAddr = axiIn.awaddr;
      st_nxt.rsp.awready = 1'b0;
    end
    if (axiIn.wvalid && st_r.rsp.wready) begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wData = axiIn.wdata[7:0];
      st_nxt.wByte = axiIn.wstrb[0];
      st_nxt.rsp.wready = 1'b0;
    end
    if (st_r.rsp.bvalid && axiIn.bready) begin
      st_nxt.rsp.bvalid = 1'b0;
    end
    doWrite = st_r.awHeld && st_r.wHeld && !st_r.rsp.bvalid;
    if (doWrite) begin
      rd = readReg(st_r, st_r.awAddr);
      wrHit = rd[32];
      st_nxt.awHeld = 1'b0;
      st_nxt.wHeld = 1'b0;
      st_nxt.rsp.awready = 1'b1;
      st_nxt.rsp.wready = 1'b1;
      st_nxt.rsp.bvalid = 1'b1;
      st_nxt.rsp.bresp = wrHit ? `TMR16_RESP_OKAY : `TMR16_RESP_SLVERR;
    end
    // Read answered one cycle after the address is taken
    if (st_r.rsp.rvalid && axiIn.rready) begin
      st_nxt.rsp.rvalid = 1'b0;
      st_nxt.rsp.arready = 1'b1;
    end
    if (axiIn.arvalid && st_r.rsp.arready) begin
      rd = readReg(st_r, axiIn.araddr);
      st_nxt.rsp.arready = 1'b0;
      st_nxt.rsp.rvalid = 1'b1;
      st_nxt.rsp.rdata = rd[31:0];
      st_nxt.rsp.rresp = rd[32] ? `TMR16_RESP_OKAY : `TMR16_RESP_SLVERR;
    end
    // Software side; hardware events below override clears
    if (doWrite && wrHit && st_r.wByte) begin
      if (st_r.awAddr == `TMR16_OFF_CTRL1) begin
        st_nxt.divSel = d[`TMR16_C1_DIV_HI:`TMR16_C1_DIV_LO];
        st_nxt.reloadEn = d[`TMR16_C1_RELOAD];
        st_nxt.run = d[`TMR16_C1_RUN];
        st_nxt.irqEn.ovf = d[`TMR16_C1_OVERFLOW_IRQ_EN];
        st_nxt.ovfToggleSel = d[`TMR16_C1_OVFTOG];
        if (!d[`TMR16_C1_OVFFLAG]) begin
          st_nxt.flags.ovf = 1'b0; // Writing one has no effect
        end
      end else if (st_r.awAddr == `TMR16_OFF_CTRL2) begin
        st_nxt.pulseOutEn = d[`TMR16_C2_PULSE_EN];
        st_nxt.pulsePol = d[`TMR16_C2_PULSE_POL];
        st_nxt.pulseToggleSel = d[`TMR16_C2_PULSE_TOG];
        st_nxt.startSel = {d[`TMR16_C2_SRC_HI], d[`TMR16_C2_SRC_LO]};
        st_nxt.polA = d[`TMR16_C2_POL_A];
        st_nxt.polB = d[`TMR16_C2_POL_B];
      end else if (st_r.awAddr == `TMR16_OFF_IRQEN) begin
        st_nxt.irqEn = tmr16_pkg::flags_t'(d[4:0]);
      end else if (st_r.awAddr == `TMR16_OFF_FLAGS) begin
        st_nxt.flags = st_r.flags & ~tmr16_pkg::flags_t'(d[4:0]);
      end else if (st_r.awAddr == `TMR16_OFF_CMP_HI ||
                   st_r.awAddr == `TMR16_OFF_RELOAD_CAPTURE_REG_HI ||
                   st_r.awAddr == `TMR16_OFF_MASK_HI) begin
        st_nxt.stage = d; // One staging byte for all targets
      end else if (st_r.awAddr == `TMR16_OFF_CMP_LO) begin
        st_nxt.cmp = {st_r.stage, d}; // Stage kept for next low
      end else if (st_r.awAddr == `TMR16_OFF_RELOAD_CAPTURE_REG_LO) begin
        st_nxt.reload_capture_reg = {st_r.stage, d};
      end else if (st_r.awAddr == `TMR16_OFF_MASK_LO) begin
        st_nxt.mask = {st_r.stage, d};
      end
    end
    // Start trigger by source pair; set run is a rising edge
    runRise = st_r.run && !st_r.runPrev;
    st_nxt.runPrev = st_r.run;
    case (tmr16_pkg::start_src_t'(st_r.startSel))
      tmr16_pkg::SRC_A: startEv = evA;
      tmr16_pkg::SRC_B: startEv = evB;
      tmr16_pkg::SRC_RUN: startEv = runRise;
      default: startEv = 1'b0;
    endcase
    startEv = startEv && st_r.reloadEn;
    // Zero mask would match each tick; one bit halves it
    effMask = (st_r.mask == 16'h0000) ? `TMR16_MASK_ZERO_EFF : st_r.mask;
    counting = st_r.run && tick && (!st_r.reloadEn || st_r.started);
    zeroHit = counting && ((st_r.count & effMask) == 16'h0000);
    cmpHit = counting &&
             ((st_r.count & effMask) == (st_r.cmp & effMask));
    ovfHit = counting && (st_r.count == 16'h0000);
    // Stopped means cleared; registers and mode bits untouched
    if (!st_r.run) begin
      st_nxt.count = 16'h0000;
      st_nxt.started = 1'b0;
    end else begin
      if (evB) begin
        st_nxt.cap = st_r.count; // Captured before any reload
      end
      if (evA && !st_r.reloadEn) begin
        st_nxt.reload_capture_reg = st_r.count; // Capture wins over a write
      end
      if (startEv) begin
        st_nxt.count = st_r.reload_capture_reg;
        st_nxt.started = 1'b1;
      end else if (ovfHit) begin
        // Underflow reload choice
        st_nxt.count = st_r.reloadEn ? st_r.reload_capture_reg : `TMR16_ALL_ONES;
      end else if (counting) begin
        st_nxt.count = st_r.count - 16'h0001;
      end
    end
    // Sets come last so they win over a clear in the same cycle
    if (evA) st_nxt.flags.evA = 1'b1;
    if (evB) st_nxt.flags.evB = 1'b1;
    if (ovfHit) st_nxt.flags.ovf = 1'b1;
    if (zeroHit) st_nxt.flags.zero = 1'b1;
    if (cmpHit) st_nxt.flags.cmp = 1'b1;
    // Pulse output; in set/reset mode zero wins if both match at once
    if (!st_r.pulseOutEn) begin
      st_nxt.pulse = st_r.pulsePol;
    end else if (st_r.pulseToggleSel) begin
      if (cmpHit) st_nxt.pulse = !st_r.pulse;
    end else if (zeroHit) begin
      st_nxt.pulse = st_r.pulsePol;
    end else if (cmpHit) begin
      st_nxt.pulse = !st_r.pulsePol;
    end
    // Overflow output follows flag or toggles
    if (st_r.ovfToggleSel) begin
      if (ovfHit) st_nxt.ovfOut = !st_r.ovfOut;
    end else begin
      st_nxt.ovfOut = st_nxt.flags.ovf;
    end
    st_nxt.irq = |(st_nxt.flags & st_nxt.irqEn);
  end

  // Single state register; bus ready lines high out of reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.rsp.awready <= 1'b1;
      st_r.rsp.wready <= 1'b1;
      st_r.rsp.arready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence seqCmpLoWrite;
    doWrite && wrHit && st_r.wByte && st_r.awAddr == `TMR16_OFF_CMP_LO;
  endsequence

  sequence seqUnderflowFree;
    ovfHit && !st_r.reloadEn;
  endsequence

  sequence seqUnderflowReload;
    ovfHit && st_r.reloadEn && !startEv;
  endsequence

  chk_run_clear: assert property (
    !st_r.run |=> st_r.count == 16'h0000)
    else $error("counter not cleared while stopped");

  chk_hi_lo_commit: assert property (
    seqCmpLoWrite |=> st_r.cmp == {$past(st_r.stage), $past(st_r.wData)})
    else $error("compare commit not staged high plus low");

  chk_underflow_full: assert property (
    seqUnderflowFree |=> st_r.count == 16'hffff)
    else $error("free underflow did not load all ones");

  chk_underflow_reload: assert property (
    seqUnderflowReload |=> st_r.count == $past(st_r.reload_capture_reg))
    else $error("underflow did not load reload value");

  chk_ovf_flag_set: assert property (
    ovfHit |=> st_r.flags.ovf ##1 (st_r.flags.ovf || $past(doWrite)))
    else $error("overflow flag not set or lost");

  chk_capture_b: assert property (
    (st_r.run && evB) |=> st_r.cap == $past(st_r.count))
    else $error("event B did not capture counter");

  chk_pulse_static: assert property (
    (!st_r.pulseOutEn ##1 !st_r.pulseOutEn)
      |-> pulseOut == $past(st_r.pulsePol))
    else $error("disabled pulse pin not at polarity");

  chk_pulse_toggle: assert property (
    (st_r.pulseOutEn && st_r.pulseToggleSel && cmpHit)
      |=> pulseOut != $past(pulseOut))
    else $error("toggle mode missed a compare match");

  chk_ovf_toggle: assert property (
    (st_r.ovfToggleSel && ovfHit) |=> overflowOut != $past(overflowOut))
    else $error("overflow pin did not toggle");

  chk_irq_or: assert property (
    irq == |(st_r.flags & st_r.irqEn))
    else $error("interrupt not OR of enabled flags");

endmodule : auto_reload_timer16
`default_nettype wire

// ==== rtl/event_edge_sync.sv ====
// Purpose: Bring an event pin into the clock domain and find its edge
// Assumes: Pin may change at any time
// Notes: Edge found between second and third stage only
`default_nettype none
module event_edge_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pinIn,
  input wire logic activeHigh,
  input wire logic enable,
  output logic edgeSeen
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_st_t;

  sync_st_t st_r;
  sync_st_t st_nxt;

  // First stage feeds only the second, against metastability
  always_comb begin
    st_nxt.s1 = pinIn;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    edgeSeen = enable && (st_r.s2 != st_r.s3) && (st_r.s2 == activeHigh);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : event_edge_sync
`default_nettype wire

// ==== rtl/tick_prescaler.sv ====
// Purpose: Divide the system clock into counter ticks of 1, 4 or 16
// Assumes: Divider choice only changes while stopped
// Notes: Cleared while disabled so the first tick timing is known
`default_nettype none
`include "tmr16_map.svh"
module tick_prescaler (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  input wire tmr16_pkg::div_sel_t divSel,
  output logic tick
);

  typedef struct packed {
    logic [3:0] cnt;
  } pre_st_t;

  pre_st_t st_r;
  pre_st_t st_nxt;

  // Tap the free count at the chosen ratio
  always_comb begin
    st_nxt = st_r;
    tick = 1'b0;
    if (!enable || divSel == tmr16_pkg::DIV_OFF) begin
      st_nxt.cnt = 4'h0;
    end else begin
      st_nxt.cnt = st_r.cnt + 4'h1;
      case (divSel)
        tmr16_pkg::DIV_1: tick = 1'b1;
        tmr16_pkg::DIV_4: tick = (st_r.cnt[1:0] == 2'(`TMR16_DIV4_LAST));
        default: tick = (st_r.cnt == `TMR16_DIV16_LAST);
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : tick_prescaler
`default_nettype wire

// ==== rtl/tmr16_map.svh ====
// Purpose: Offsets, field positions and constant values of the 16-bit timer
// Assumes: AXI4-Lite byte addresses, one register per aligned word
// Notes: Definitions only
`ifndef TMR16_MAP_SVH
`define TMR16_MAP_SVH

// Register byte offsets
`define TMR16_OFF_CTRL1 8'h00
`define TMR16_OFF_CTRL2 8'h04
`define TMR16_OFF_IRQEN 8'h08
`define TMR16_OFF_FLAGS 8'h0c
`define TMR16_OFF_CMP_HI 8'h10
`define TMR16_OFF_CMP_LO 8'h14
`define TMR16_OFF_RELOAD_CAPTURE_REG_HI 8'h18
`define TMR16_OFF_RELOAD_CAPTURE_REG_LO 8'h1c
`define TMR16_OFF_MASK_HI 8'h20
`define TMR16_OFF_MASK_LO 8'h24
`define TMR16_OFF_CAP_HI 8'h28
`define TMR16_OFF_CAP_LO 8'h2c
`define TMR16_OFF_CNT_HI 8'h30
`define TMR16_OFF_CNT_LO 8'h34

// Control 1 fields
`define TMR16_C1_DIV_HI 7
`define TMR16_C1_DIV_LO 6
`define TMR16_C1_RELOAD 5
`define TMR16_C1_RUN 4
`define TMR16_C1_OVERFLOW_IRQ_EN 3
`define TMR16_C1_OVFFLAG 2
`define TMR16_C1_OVFTOG 1

// Control 2 fields
`define TMR16_C2_PULSE_EN 0
`define TMR16_C2_PULSE_POL 1
`define TMR16_C2_PULSE_TOG 2
`define TMR16_C2_SRC_LO 3
`define TMR16_C2_SRC_HI 4
`define TMR16_C2_POL_A 5
`define TMR16_C2_POL_B 6

// Flag and enable fields
`define TMR16_F_EVA 0
`define TMR16_F_EVB 1
`define TMR16_F_OVF 2
`define TMR16_F_CMP 3
`define TMR16_F_ZERO 4

// Values
`define TMR16_ALL_ONES 16'hffff
`define TMR16_MASK_ZERO_EFF 16'h0001
`define TMR16_DIV4_LAST 4'h3
`define TMR16_DIV16_LAST 4'hf
`define TMR16_RESP_OKAY 2'h0
`define TMR16_RESP_SLVERR 2'h2

`endif

// ==== rtl/tmr16_pkg.sv ====
// Purpose: Types shared by the 16-bit timer files
// Assumes: Offsets and positions live in tmr16_map.svh
// Notes: Bus carriers are packed structs
`default_nettype none
package tmr16_pkg;

  typedef enum logic [1:0] {
    DIV_OFF = 2'b00,
    DIV_1 = 2'b01,
    DIV_4 = 2'b10,
    DIV_16 = 2'b11
  } div_sel_t;

  typedef enum logic [1:0] {
    SRC_RUN = 2'b00,
    SRC_A = 2'b01,
    SRC_B = 2'b10,
    SRC_NONE = 2'b11
  } start_src_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  // Flags and their enables share one layout
  typedef struct packed {
    logic zero;
    logic cmp;
    logic ovf;
    logic evB;
    logic evA;
  } flags_t;

endpackage : tmr16_pkg
`default_nettype wire

// ==== verification/auto_reload_timer16_tb.sv ====
// Purpose: Self-checking bench for the 16-bit auto-reload timer
// Assumes: Partner master drives the register bus
// Notes: Periods are measured between output edges, not from start
`default_nettype none
`include "tmr16_map.svh"
module auto_reload_timer16_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic refClk;
  logic rst;
  logic eventInA;
  logic eventInB;
  logic pulseOut;
  logic overflowOut;
  logic irq;
  tmr16_pkg::axi_req_t axiIn;
  tmr16_pkg::axi_rsp_t axiOut;
  int errorCnt;
  int samplesChecked;
  int cyc;
  logic [31:0] rdVal;
  logic [1:0] resp;
  logic [7:0] hiB;
  logic [7:0] loB;
  logic [7:0] nVal;
  tmr16_pkg::div_sel_t divs[3];

  auto_reload_timer16 dut (
    .ref_clk(refClk),
    .rst(rst),
    .axiIn(axiIn),
    .axiOut(axiOut),
    .eventInA(eventInA),
    .eventInB(eventInB),
    .pulseOut(pulseOut),
    .overflowOut(overflowOut),
    .irq(irq)
  );

  axi_lite_master bus (.ref_clk(refClk), .req(axiIn), .rsp(axiOut));

  // 40 MHz clock
  initial begin
    refClk = 1'b0;
    forever #12.5 refClk = ~refClk;
  end

  function automatic logic [7:0] ctl1(input tmr16_pkg::div_sel_t dv,
      input logic rl, input logic run, input logic tog);
    return {dv, rl, run, 2'b00, tog, 1'b0};
  endfunction : ctl1

  function automatic int divFactor(input tmr16_pkg::div_sel_t dv);
    return (dv == tmr16_pkg::DIV_1) ? 1 : (dv == tmr16_pkg::DIV_4) ? 4 : 16;
  endfunction : divFactor

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errorCnt++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus.wr(a, d, resp);
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    bus.rd(a, rdVal, resp);
    check(rdVal, {24'h0, exp});
  endtask : rdChk

  // Cycles between two successive changes of one output
  task automatic measure(input logic usePulse, output int n);
    logic last;
    logic now;
    n = -1;
    last = usePulse ? pulseOut : overflowOut;
    for (int i = 0; i < 4000; i++) begin
      @(posedge refClk);
      now = usePulse ? pulseOut : overflowOut;
      if (n >= 0) n++;
      if (now !== last) begin
        last = now;
        if (n > 0) break;
        n = 0;
      end
    end
  endtask : measure

  task automatic printVerdict();
    $display("Counts: %0d mismatches, %0d checks", errorCnt, samplesChecked);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : printVerdict

  // Hang guard, far above the expected run length
  initial begin
    repeat (60000) @(posedge refClk);
    errorCnt++;
    printVerdict();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    eventInA = 1'b0;
    eventInB = 1'b0;
    errorCnt = 0;
    samplesChecked = 0;
    divs = '{tmr16_pkg::DIV_1, tmr16_pkg::DIV_4, tmr16_pkg::DIV_16};
    void'($urandom(85217));
    repeat (8) @(posedge refClk);
    rst <= 1'b0;
    rdChk(`TMR16_OFF_CNT_LO, 8'h00);
    wr(`TMR16_OFF_CTRL1, 8'h04);
    rdChk(`TMR16_OFF_CTRL1, 8'h00);
    bus.rd(8'h38, rdVal, resp);
    check(32'(resp), 32'h2);
    hiB = 8'($urandom_range(255));
    loB = 8'($urandom_range(255));
    wr(`TMR16_OFF_CMP_HI, hiB);
    wr(`TMR16_OFF_CMP_LO, loB);
    rdChk(`TMR16_OFF_CMP_HI, hiB);
    rdChk(`TMR16_OFF_CMP_LO, loB);
    wr(`TMR16_OFF_RELOAD_CAPTURE_REG_LO, ~loB);
    rdChk(`TMR16_OFF_RELOAD_CAPTURE_REG_HI, hiB);
    rdChk(`TMR16_OFF_RELOAD_CAPTURE_REG_LO, ~loB);
    $display("test staging done");
    // Full mask, nonzero compare, toggle on both outputs
    wr(`TMR16_OFF_MASK_HI, 8'hff);
    wr(`TMR16_OFF_MASK_LO, 8'hff);
    wr(`TMR16_OFF_CMP_HI, 8'h00);
    wr(`TMR16_OFF_CMP_LO, 8'h01);
    wr(`TMR16_OFF_CTRL2, 8'h05);
    foreach (divs[i]) begin
      nVal = 8'($urandom_range(40, 4));
      wr(`TMR16_OFF_CTRL1, 8'h00);
      wr(`TMR16_OFF_RELOAD_CAPTURE_REG_HI, 8'h00);
      wr(`TMR16_OFF_RELOAD_CAPTURE_REG_LO, nVal);
      wr(`TMR16_OFF_CTRL1, ctl1(divs[i], 1'b1, 1'b0, 1'b1));
      wr(`TMR16_OFF_CTRL1, ctl1(divs[i], 1'b1, 1'b1, 1'b1));
      measure(1'b0, cyc);
      check(32'(cyc), 32'((nVal + 1) * divFactor(divs[i])));
      measure(1'b1, cyc);
      check(32'(cyc), 32'((nVal + 1) * divFactor(divs[i])));
    end
    $display("test reload periods done");
    wr(`TMR16_OFF_CTRL1, ctl1(tmr16_pkg::DIV_16, 1'b1, 1'b0, 1'b1));
    rdChk(`TMR16_OFF_CNT_HI, 8'h00);
    rdChk(`TMR16_OFF_CNT_LO, 8'h00);
    rdChk(`TMR16_OFF_RELOAD_CAPTURE_REG_LO, nVal);
    rdChk(`TMR16_OFF_MASK_LO, 8'hff);
    rdChk(`TMR16_OFF_CTRL2, 8'h05);
    wr(`TMR16_OFF_CTRL1, ctl1(tmr16_pkg::DIV_16, 1'b1, 1'b1, 1'b1));
    measure(1'b0, cyc);
    check(32'(cyc), 32'((nVal + 1) * 16));
    $display("test stop and resume done");
    // Free run: divider off holds, then first tick underflows
    wr(`TMR16_OFF_CTRL1, 8'h00);
    wr(`TMR16_OFF_CTRL1, ctl1(tmr16_pkg::DIV_OFF, 1'b0, 1'b1, 1'b0));
    rdChk(`TMR16_OFF_CNT_LO, 8'h00);
    // Match flags left over from the reload runs would hide the next ones
    wr(`TMR16_OFF_FLAGS, 8'h1f);
    wr(`TMR16_OFF_CTRL1, ctl1(tmr16_pkg::DIV_1, 1'b0, 1'b1, 1'b0));
    rdChk(`TMR16_OFF_CNT_HI, 8'hff);
    rdChk(`TMR16_OFF_CTRL1, 8'h54);
    rdChk(`TMR16_OFF_FLAGS, 8'h14);
    check(32'(overflowOut), 32'h1);
    wr(`TMR16_OFF_CTRL1, ctl1(tmr16_pkg::DIV_1, 1'b0, 1'b1, 1'b0));
    repeat (2) @(posedge refClk);
    check(32'(overflowOut), 32'h0);
    $display("test free run done");
    // Events: flags first, enable afterwards must raise the interrupt
    wr(`TMR16_OFF_CTRL2, 8'h60);
    repeat ($urandom_range(9)) @(posedge refClk);
    eventInA <= 1'b1;
    repeat (8) @(posedge refClk);
    check(32'(irq), 32'h0);
    // Zero match flag from the free run start is still set
    rdChk(`TMR16_OFF_FLAGS, 8'h11);
    rdChk(`TMR16_OFF_RELOAD_CAPTURE_REG_HI, 8'hff);
    wr(`TMR16_OFF_IRQEN, 8'h01);
    repeat (2) @(posedge refClk);
    check(32'(irq), 32'h1);
    eventInB <= 1'b1;
    repeat (8) @(posedge refClk);
    rdChk(`TMR16_OFF_FLAGS, 8'h13);
    rdChk(`TMR16_OFF_CAP_HI, 8'hff);
    wr(`TMR16_OFF_FLAGS, 8'h03);
    repeat (2) @(posedge refClk);
    check(32'(irq), 32'h0);
    eventInA <= 1'b0;
    eventInB <= 1'b0;
    $display("test events done");
    for (int p = 0; p < 2; p++) begin
      wr(`TMR16_OFF_CTRL2, 8'(p * 2));
      repeat (2) @(posedge refClk);
      check(32'(pulseOut), 32'(p));
    end
    $display("test pulse idle done");
    // Zero mask, set/reset: zero and odd compare alternate each tick
    wr(`TMR16_OFF_MASK_HI, 8'h00);
    wr(`TMR16_OFF_MASK_LO, 8'h00);
    wr(`TMR16_OFF_CTRL2, 8'h63);
    wr(`TMR16_OFF_CTRL1, 8'h00);
    wr(`TMR16_OFF_CTRL1, ctl1(tmr16_pkg::DIV_4, 1'b0, 1'b1, 1'b0));
    measure(1'b1, cyc);
    check(32'(cyc), 32'(divFactor(tmr16_pkg::DIV_4)));
    $display("test zero mask done");
    // Reload mode started by pin A, then pin B; run rise alone must not
    wr(`TMR16_OFF_RELOAD_CAPTURE_REG_LO, nVal);
    for (int p = 0; p < 2; p++) begin
      wr(`TMR16_OFF_CTRL1, 8'h00);
      wr(`TMR16_OFF_CTRL2, 8'(8'h68 + p * 8));
      wr(`TMR16_OFF_CTRL1, ctl1(tmr16_pkg::DIV_1, 1'b1, 1'b1, 1'b1));
      rdChk(`TMR16_OFF_CNT_LO, 8'h00);
      if (p == 0) begin
        eventInA <= 1'b1;
      end else begin
        eventInB <= 1'b1;
      end
      measure(1'b0, cyc);
      check(32'(cyc), 32'(nVal + 1));
      eventInA <= 1'b0;
      eventInB <= 1'b0;
    end
    rdChk(`TMR16_OFF_CAP_LO, 8'h00);
    $display("test event start done");
    printVerdict();
  end
endmodule : auto_reload_timer16_tb
`default_nettype wire

// ==== verification/axi_lite_master.sv ====
// Purpose: Processor-side register master for the 16-bit timer
// Assumes: AXI4-Lite, one write and one read in flight at most
// Notes: Byte contents travel in wdata[7:0], upper bits zero
`default_nettype none
module axi_lite_master (
  input wire logic ref_clk,
  output var tmr16_pkg::axi_req_t req,
  input wire tmr16_pkg::axi_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus from time zero
  initial req = '0;

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [1:0] resp);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge ref_clk);
    req.awaddr <= a;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'h1;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge ref_clk);
      if (!awDone && rsp.awready) begin
        awDone = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!wDone && rsp.wready) begin
        wDone = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    // Response only counts once both halves were taken
    do begin
      @(posedge ref_clk);
    end while (!rsp.bvalid);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr

  // Read data taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    logic arDone;
    arDone = 1'b0;
    @(posedge ref_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (!arDone && rsp.arready) begin
        arDone = 1'b1;
        req.arvalid <= 1'b0;
      end
    end while (!(arDone && rsp.rvalid));
    d = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd
endmodule : axi_lite_master
`default_nettype wire
